// File: tnv_pkg.sv
// Summary of operation
// RULE1: Serial data from the bus is sampled on the rising bus-clock edge and outgoing data changes on the falling edge.
// RULE2: While write protect is high, no location of the array is ever altered.
// RULE3: While write protect is low, every address of the array is written normally.
// RULE4: An undriven write-protect input reads low, so the memory then behaves as unprotected.
// RULE5: The array holds 2,048 separately addressed bytes of 8 bits, each shifted serially on the bus.
// RULE6: The 11-bit byte address joins a 3-bit segment selecting one of 8 segments with an 8-bit row selecting one of 256.
// RULE7: Each array write completes within the bus edge that ends the byte, so the next access is accepted at once.
// RULE8: A simple power-on reset puts the interface logic into a defined idle state.
// RULE9: A start or stop aborts the operation in progress, and a start also prepares decoding of a new slave address.
// RULE10: The address latch increments after each transferred byte, before the acknowledge, and wraps from the top to zero.
// RULE11: With write protect active, written data bytes are not acknowledged and the address counter does not move.
// RULE12: The master sends a slave-address byte with the segment in bits 3 to 1 and the direction in bit 0, 0 meaning write.
// RULE13: During a read the memory releases data for the acknowledge, sends on only after an acknowledge, and ends on none.
package tnv_pkg;

    localparam int DATA_W   = 8;
    localparam int ROW_W    = 8;
    localparam int SEG_W    = 3;
    localparam int ADDR_W   = 11;
    localparam int DEPTH    = 2048;

    // Slave-address field positions.
    localparam int SA_TYPE_LSB = 4;
    localparam int SA_SEG_LSB  = 1;
    localparam int SA_RW_BIT   = 0;

    localparam logic [2:0]        BIT_LAST  = 3'h7;
    localparam logic [2:0]        BIT_ZERO  = 3'h0;
    localparam logic [2:0]        BIT_ONE   = 3'h1;
    localparam logic [ADDR_W-1:0] ADDR_LAST = 11'h7ff;
    localparam logic [ADDR_W-1:0] ADDR_ZERO = 11'h000;
    localparam logic [ADDR_W-1:0] ADDR_ONE  = 11'h001;

    typedef struct packed {
        logic [SEG_W-1:0] seg;
        logic [ROW_W-1:0] row;
    } tnv_addr_type;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_DEVADDR,
        ST_WORDADR,
        ST_WRDATA,
        ST_ACKOUT,
        ST_RDDATA,
        ST_ACKIN
    } tnv_state_type;

endpackage

// File: tnv_array.sv
`timescale 1ns/100ps
`default_nettype none

module tnv_array (
    // Clock.
    input  wire logic                       clk,
    // Write port.
    input  wire logic                       we,
    input  wire logic [tnv_pkg::DATA_W-1:0] wdata,
    // Shared address and read data.
    input  wire logic [tnv_pkg::ADDR_W-1:0] addr,
    output logic      [tnv_pkg::DATA_W-1:0] rdata
);

    // ----------------------------------------------------------------
    // Storage
    // ----------------------------------------------------------------
    // The array has no reset: its contents survive any reset of the interface.
    logic [tnv_pkg::DATA_W-1:0] mem_r [tnv_pkg::DEPTH]; // RULE5

    always_ff @(posedge clk) begin
        if (we) begin
            mem_r[addr] <= wdata; // RULE7
        end
    end

    assign rdata = mem_r[addr];

endmodule
`default_nettype wire

// File: tnv_slave.sv
`timescale 1ns/100ps
`default_nettype none

module tnv_slave #(
    // Device-type code; the value is arbitrary.
    parameter logic [3:0] DEV_TYPE = 4'h5
) (
    // System clock and reset.
    input  wire logic clk,
    input  wire logic srst,
    // Two-wire bus.
    input  wire logic scl,
    input  wire logic sda_i,
    output logic      sda_o,
    output logic      sda_oe,
    // Write protect pin.
    input  wire logic wp
);

    // ----------------------------------------------------------------
    // Declarations
    // ----------------------------------------------------------------
    logic                         por_r;
    logic                         rst_m_r;
    logic                         scl_rst_r;
    logic                         wp_m1_r;
    logic                         wp_m2_r;
    logic                         wp_m3_r;
    logic                         wp_f_r;
    logic                         wp_s1_r;
    logic                         wp_l_r;
    logic                         sda_o_r;
    logic                         sda_oe_r;
    logic                         start_tog_r;
    logic                         stop_tog_r;
    logic                         start_seen_r;
    logic                         stop_seen_r;
    logic                         start_ev;
    logic                         stop_ev;
    logic                         byte_end;
    logic                         dev_match;
    logic                         mem_we;
    logic                         ack_r;
    logic [2:0]                   cnt_r;
    logic [6:0]                   sh_r;
    logic [tnv_pkg::DATA_W-1:0]   rx_byte;
    logic [tnv_pkg::DATA_W-1:0]   tx_r;
    logic [tnv_pkg::DATA_W-1:0]   rd_data;
    tnv_pkg::tnv_addr_type        addr_r;
    tnv_pkg::tnv_state_type       st_r;
    tnv_pkg::tnv_state_type       after_r;

    function automatic tnv_pkg::tnv_addr_type next_addr(input tnv_pkg::tnv_addr_type a);
        if (a == tnv_pkg::ADDR_LAST) begin
            next_addr = tnv_pkg::ADDR_ZERO;
        end else begin
            next_addr = a + tnv_pkg::ADDR_ONE;
        end
    endfunction

    // ----------------------------------------------------------------
    // System-clock domain: reset capture and write-protect filter
    // ----------------------------------------------------------------
    always_ff @(posedge clk) begin
        por_r <= srst; // RULE8
    end

    // Three stages; the filtered level moves only when the last two agree.
    always_ff @(posedge clk) begin
        if (srst) begin
            wp_m1_r <= 1'b0;
            wp_m2_r <= 1'b0;
            wp_m3_r <= 1'b0;
            wp_f_r  <= 1'b0; // RULE4
        end else begin
            wp_m1_r <= wp;
            wp_m2_r <= wp_m1_r;
            wp_m3_r <= wp_m2_r;
            if (wp_m2_r == wp_m3_r) begin
                wp_f_r <= wp_m3_r;
            end
        end
    end

    // The data pin is open drain: only a low is ever driven.
    always_ff @(posedge clk) begin
        sda_o_r <= 1'b0;
    end

    // ----------------------------------------------------------------
    // Bus-clock domain: reset and write-protect synchronisers
    // ----------------------------------------------------------------
    always_ff @(posedge scl) begin
        rst_m_r   <= por_r;
        scl_rst_r <= rst_m_r; // RULE8
    end

    always_ff @(posedge scl) begin
        if (scl_rst_r) begin
            wp_s1_r <= 1'b0;
            wp_l_r  <= 1'b0; // RULE4
        end else begin
            wp_s1_r <= wp_f_r;
            wp_l_r  <= wp_s1_r;
        end
    end

    // ----------------------------------------------------------------
    // Start and stop detection
    // ----------------------------------------------------------------
    // A data edge while the bus clock is high toggles a flag. The protocol
    // keeps the next rising bus-clock edge half a period away, which gives
    // the bus-clock flops their setup time on the toggles.
    always_ff @(negedge sda_i or posedge scl_rst_r) begin
        if (scl_rst_r) begin
            start_tog_r <= 1'b0;
        end else if (scl) begin
            start_tog_r <= ~start_tog_r; // RULE9
        end
    end

    always_ff @(posedge sda_i or posedge scl_rst_r) begin
        if (scl_rst_r) begin
            stop_tog_r <= 1'b0;
        end else if (scl) begin
            stop_tog_r <= ~stop_tog_r; // RULE9
        end
    end

    always_ff @(posedge scl) begin
        if (scl_rst_r) begin
            start_seen_r <= 1'b0;
            stop_seen_r  <= 1'b0;
        end else begin
            start_seen_r <= start_tog_r;
            stop_seen_r  <= stop_tog_r;
        end
    end

    assign start_ev  = start_tog_r != start_seen_r;
    assign stop_ev   = stop_tog_r != stop_seen_r;
    assign rx_byte   = {sh_r, sda_i}; // RULE1
    assign byte_end  = (cnt_r == tnv_pkg::BIT_LAST) && !start_ev && !stop_ev;
    assign dev_match = rx_byte[tnv_pkg::DATA_W-1:tnv_pkg::SA_TYPE_LSB] == DEV_TYPE;
    assign mem_we    = (st_r == tnv_pkg::ST_WRDATA) && byte_end && !wp_l_r; // RULE2 RULE3

    // ----------------------------------------------------------------
    // Sequencer
    // ----------------------------------------------------------------
    always_ff @(posedge scl) begin
        if (scl_rst_r) begin
            st_r    <= tnv_pkg::ST_IDLE; // RULE8
            cnt_r   <= tnv_pkg::BIT_ZERO;
            sh_r    <= 7'h00;
            after_r <= tnv_pkg::ST_IDLE;
        end else if (start_ev) begin
            st_r  <= tnv_pkg::ST_DEVADDR; // RULE9
            cnt_r <= tnv_pkg::BIT_ONE;
            sh_r  <= {6'h00, sda_i};
        end else if (stop_ev) begin
            st_r  <= tnv_pkg::ST_IDLE; // RULE9
            cnt_r <= tnv_pkg::BIT_ZERO;
        end else begin
            case (st_r)
                tnv_pkg::ST_DEVADDR, tnv_pkg::ST_WORDADR, tnv_pkg::ST_WRDATA: begin
                    sh_r  <= rx_byte[6:0];
                    cnt_r <= cnt_r + tnv_pkg::BIT_ONE;
                    if (byte_end) begin
                        st_r <= tnv_pkg::ST_ACKOUT;
                        if (st_r == tnv_pkg::ST_DEVADDR) begin
                            if (!dev_match) begin
                                st_r <= tnv_pkg::ST_IDLE;
                            end
                            after_r <= rx_byte[tnv_pkg::SA_RW_BIT] ? tnv_pkg::ST_RDDATA
                                                                   : tnv_pkg::ST_WORDADR; // RULE12
                        end else begin
                            after_r <= tnv_pkg::ST_WRDATA;
                        end
                    end
                end
                tnv_pkg::ST_ACKOUT: begin
                    st_r <= ack_r ? after_r : tnv_pkg::ST_IDLE; // RULE11
                end
                tnv_pkg::ST_RDDATA: begin
                    cnt_r <= cnt_r + tnv_pkg::BIT_ONE;
                    if (byte_end) begin
                        st_r <= tnv_pkg::ST_ACKIN;
                    end
                end
                tnv_pkg::ST_ACKIN: begin
                    st_r <= sda_i ? tnv_pkg::ST_IDLE : tnv_pkg::ST_RDDATA; // RULE13
                end
                default: begin
                    st_r <= tnv_pkg::ST_IDLE;
                end
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Acknowledge decision
    // ----------------------------------------------------------------
    always_ff @(posedge scl) begin
        if (scl_rst_r || start_ev) begin
            ack_r <= 1'b0;
        end else if (byte_end) begin
            case (st_r)
                tnv_pkg::ST_DEVADDR: ack_r <= dev_match;
                tnv_pkg::ST_WORDADR: ack_r <= 1'b1;
                tnv_pkg::ST_WRDATA:  ack_r <= !wp_l_r; // RULE11
                default:             ack_r <= 1'b0;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Address latch
    // ----------------------------------------------------------------
    always_ff @(posedge scl) begin
        if (scl_rst_r) begin
            addr_r <= tnv_pkg::ADDR_ZERO;
        end else if (byte_end) begin
            case (st_r)
                tnv_pkg::ST_DEVADDR: begin
                    if (dev_match) begin
                        addr_r.seg <= rx_byte[tnv_pkg::SA_SEG_LSB +: tnv_pkg::SEG_W]; // RULE6 RULE12
                    end
                end
                tnv_pkg::ST_WORDADR: addr_r.row <= rx_byte; // RULE6
                tnv_pkg::ST_WRDATA: begin
                    if (!wp_l_r) begin
                        addr_r <= next_addr(addr_r); // RULE10 RULE11
                    end
                end
                tnv_pkg::ST_RDDATA: addr_r <= next_addr(addr_r); // RULE10
                default: addr_r <= addr_r;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Read data load
    // ----------------------------------------------------------------
    always_ff @(posedge scl) begin
        if (scl_rst_r) begin
            tx_r <= 8'h00;
        end else if ((st_r == tnv_pkg::ST_ACKOUT && ack_r && after_r == tnv_pkg::ST_RDDATA && !start_ev && !stop_ev)
                  || (st_r == tnv_pkg::ST_ACKIN && !sda_i && !start_ev && !stop_ev)) begin
            tx_r <= rd_data; // RULE13
        end
    end

    // ----------------------------------------------------------------
    // Data pin drive on the falling edge
    // ----------------------------------------------------------------
    always_ff @(negedge scl) begin
        if (scl_rst_r) begin
            sda_oe_r <= 1'b0;
        end else begin
            case (st_r)
                tnv_pkg::ST_ACKOUT: sda_oe_r <= ack_r; // RULE1
                tnv_pkg::ST_RDDATA: sda_oe_r <= ~tx_r[~cnt_r]; // RULE1
                default:            sda_oe_r <= 1'b0; // RULE13
            endcase
        end
    end

    assign sda_o  = sda_o_r;
    assign sda_oe = sda_oe_r;

    tnv_array u_array (
        .clk   (scl),
        .we    (mem_we),
        .wdata (rx_byte),
        .addr  (addr_r),
        .rdata (rd_data)
    );

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    reset_idle_a: assert property (@(posedge scl) scl_rst_r |=> st_r == tnv_pkg::ST_IDLE && !ack_r) // RULE8
        else $error("interface not idle after reset");

    protect_write_a: assert property (@(posedge scl) disable iff (scl_rst_r)
        (st_r == tnv_pkg::ST_WRDATA && byte_end && wp_l_r) |=> $stable(rd_data)) // RULE2
        else $error("array written while protected");

    open_write_a: assert property (@(posedge scl) disable iff (scl_rst_r)
        (st_r == tnv_pkg::ST_WRDATA && byte_end && !wp_l_r) |-> mem_we ##1 (ack_r && addr_r == next_addr($past(addr_r)))) // RULE3
        else $error("unprotected write not taken");

    wp_nack_a: assert property (@(posedge scl) disable iff (scl_rst_r)
        (st_r == tnv_pkg::ST_WRDATA && byte_end && wp_l_r) |=> !ack_r && $stable(addr_r)) // RULE11
        else $error("protected write acknowledged or address moved");

    ack_drive_a: assert property (@(posedge scl) disable iff (scl_rst_r)
        (st_r == tnv_pkg::ST_ACKOUT) |-> sda_oe == ack_r) // RULE1
        else $error("acknowledge drive mismatch");

    start_abort_a: assert property (@(posedge scl) disable iff (scl_rst_r)
        start_ev |=> st_r == tnv_pkg::ST_DEVADDR && cnt_r == tnv_pkg::BIT_ONE) // RULE9
        else $error("start did not restart address decode");

    stop_abort_a: assert property (@(posedge scl) disable iff (scl_rst_r)
        (stop_ev && !start_ev) |-> !mem_we ##1 st_r == tnv_pkg::ST_IDLE) // RULE9
        else $error("stop did not abort");

    row_load_a: assert property (@(posedge scl) disable iff (scl_rst_r)
        (st_r == tnv_pkg::ST_WORDADR && byte_end) |=> addr_r.row == $past(rx_byte)) // RULE6
        else $error("row address not loaded");

    rd_release_a: assert property (@(posedge scl) disable iff (scl_rst_r)
        (st_r == tnv_pkg::ST_ACKIN) |-> !sda_oe) // RULE13
        else $error("data pin held during master acknowledge");

    rd_nack_a: assert property (@(posedge scl) disable iff (scl_rst_r)
        (st_r == tnv_pkg::ST_ACKIN && sda_i && !start_ev && !stop_ev) |=> st_r == tnv_pkg::ST_IDLE ##1 !sda_oe) // RULE13
        else $error("read continued without acknowledge");

    rd_inc_a: assert property (@(posedge scl) disable iff (scl_rst_r)
        (st_r == tnv_pkg::ST_RDDATA && byte_end) |=> st_r == tnv_pkg::ST_ACKIN
                                                    && addr_r == next_addr($past(addr_r))) // RULE10
        else $error("read address not advanced");

    write_cov_c: cover property (@(posedge scl) disable iff (scl_rst_r) mem_we ##1 st_r == tnv_pkg::ST_ACKOUT);
    read_cov_c:  cover property (@(posedge scl) disable iff (scl_rst_r)
        st_r == tnv_pkg::ST_ACKIN && !sda_i ##1 st_r == tnv_pkg::ST_RDDATA);
    wrap_cov_c:  cover property (@(posedge scl) disable iff (scl_rst_r)
        byte_end && addr_r == tnv_pkg::ADDR_LAST ##1 addr_r == tnv_pkg::ADDR_ZERO);
    prot_cov_c:  cover property (@(posedge scl) disable iff (scl_rst_r)
        st_r == tnv_pkg::ST_WRDATA && byte_end && wp_l_r);

endmodule
`default_nettype wire

// File: tnv_bus_master.sv
`timescale 1ns/100ps
`default_nettype none

module tnv_bus_master (
    // Two-wire bus.
    output logic      scl,
    output logic      m_low,
    input  wire logic sda
);
    initial begin
        scl   = 1'b1;
        m_low = 1'b0;
    end

    // --------------------------------------------------------------
    // Bus cycles
    // --------------------------------------------------------------
    // Clocks with both wires high, as around reset or straight after a stop.
    task automatic idle(input int n);
        repeat (n) begin
            #16 scl = 1'b0;
            #16 scl = 1'b1;
        end
    endtask

    task automatic start();
        m_low = 1'b0;
        #8 scl = 1'b1;
        #16 m_low = 1'b1;
        #16 scl = 1'b0;
    endtask

    task automatic stop();
        #8 m_low = 1'b1;
        #8 scl = 1'b1;
        #16 m_low = 1'b0;
        #16;
    endtask

    // Data changes mid-low and is sampled mid-high.
    task automatic one_bit(input logic b, output logic seen);
        #8 m_low = ~b;
        #8 scl = 1'b1;
        #8 seen = sda;
        #8 scl = 1'b0;
    endtask

    task automatic wr_bits(input logic [7:0] d, input int n);
        logic dummy;
        for (int i = 0; i < n; i++) begin
            one_bit(d[7-i], dummy);
        end
    endtask

    task automatic send(input logic [7:0] d, output logic ack);
        wr_bits(d, 8);
        one_bit(1'b1, ack);
    endtask

    // The master acknowledges to go on and stays released to end the read.
    task automatic recv(input logic nack, output logic [7:0] d);
        logic dummy;
        for (int i = 0; i < 8; i++) begin
            one_bit(1'b1, d[7-i]);
        end
        one_bit(nack, dummy);
    endtask
endmodule

`default_nettype wire

// File: tb.sv
`timescale 1ns/100ps
`default_nettype none

module tb;
    // Device-type code; the value is arbitrary.
    localparam logic [3:0] DEV_TYPE = 4'h5;

    logic clk;
    logic srst;
    logic wp_en;
    logic wp_val;
    logic sda_o;
    logic sda_oe;
    logic scl;
    logic m_low;
    wire  sda;
    tri0  wp_pin;
    int   bad_count;
    int   n_checks;

    // The write-protect pin reads low whenever the bench leaves it undriven.
    assign wp_pin = wp_en ? wp_val : 1'bz;
    assign sda    = (sda_oe ? sda_o : 1'b1) & ~m_low;

    tnv_slave #(.DEV_TYPE(DEV_TYPE)) i_tnv_slave (
        .clk    (clk),
        .srst   (srst),
        .scl    (scl),
        .sda_i  (sda),
        .sda_o  (sda_o),
        .sda_oe (sda_oe),
        .wp     (wp_pin)
    );

    tnv_bus_master i_tnv_bus_master (
        .scl   (scl),
        .m_low (m_low),
        .sda   (sda)
    );

    initial clk = 1'b0;
    always #50 clk = ~clk;

    // --------------------------------------------------------------
    // Shared tasks
    // --------------------------------------------------------------
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        n_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic give_verdict();
        $display("TB: checks=%0d mismatches=%0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    task automatic set_wp(input logic en, input logic val);
        @(posedge clk);
        #1;
        wp_en  = en;
        wp_val = val;
        repeat (8) @(posedge clk);
    endtask

    task automatic write_bytes(input logic [2:0] seg, input logic [7:0] row, input int n,
                               input logic [7:0] d0, input logic [7:0] d1, input logic dack);
        logic ack;
        i_tnv_bus_master.start();
        i_tnv_bus_master.send({DEV_TYPE, seg, 1'b0}, ack);
        check({7'h00, ack}, 8'h00);
        i_tnv_bus_master.send(row, ack);
        check({7'h00, ack}, 8'h00);
        if (n > 0) begin
            i_tnv_bus_master.send(d0, ack);
            check({7'h00, ack}, {7'h00, dack});
        end
        if (n > 1) begin
            i_tnv_bus_master.send(d1, ack);
            check({7'h00, ack}, {7'h00, dack});
        end
        i_tnv_bus_master.stop();
    endtask

    task automatic read_bytes(input logic [2:0] seg, input int n, output logic [7:0] r0, output logic [7:0] r1);
        logic ack;
        r1 = 8'h00;
        i_tnv_bus_master.start();
        i_tnv_bus_master.send({DEV_TYPE, seg, 1'b1}, ack);
        check({7'h00, ack}, 8'h00);
        i_tnv_bus_master.recv(n == 1, r0);
        if (n > 1) begin
            i_tnv_bus_master.recv(1'b1, r1);
        end
        i_tnv_bus_master.stop();
        check({7'h00, sda_oe}, 8'h00);
    endtask

    // --------------------------------------------------------------
    // Scenarios
    // --------------------------------------------------------------
    task automatic t_basic();
        logic [7:0] r0;
        logic [7:0] r1;
        write_bytes(3'h4, 8'h10, 1, 8'h5a, 8'h00, 1'b0);
        write_bytes(3'h3, 8'h10, 2, 8'ha5, 8'h3c, 1'b0);
        write_bytes(3'h3, 8'h10, 0, 8'h00, 8'h00, 1'b0);
        read_bytes(3'h3, 2, r0, r1);
        check(r0, 8'ha5);
        check(r1, 8'h3c);
        write_bytes(3'h4, 8'h10, 0, 8'h00, 8'h00, 1'b0);
        read_bytes(3'h4, 1, r0, r1);
        check(r0, 8'h5a);
        $display("test basic done");
    endtask

    task automatic t_wrap();
        logic [7:0] r0;
        logic [7:0] r1;
        write_bytes(3'h7, 8'hff, 2, 8'h11, 8'h22, 1'b0);
        write_bytes(3'h7, 8'hff, 0, 8'h00, 8'h00, 1'b0);
        read_bytes(3'h7, 2, r0, r1);
        check(r0, 8'h11);
        check(r1, 8'h22);
        write_bytes(3'h0, 8'h00, 0, 8'h00, 8'h00, 1'b0);
        read_bytes(3'h0, 1, r0, r1);
        check(r0, 8'h22);
        $display("test wrap done");
    endtask

    task automatic t_protect();
        logic [7:0] r0;
        logic [7:0] r1;
        set_wp(1'b1, 1'b1);
        write_bytes(3'h3, 8'h10, 1, 8'hff, 8'h00, 1'b1);
        set_wp(1'b1, 1'b0);
        read_bytes(3'h3, 1, r0, r1);
        check(r0, 8'ha5);
        write_bytes(3'h3, 8'h10, 1, 8'hc3, 8'h00, 1'b0);
        write_bytes(3'h3, 8'h10, 0, 8'h00, 8'h00, 1'b0);
        read_bytes(3'h3, 1, r0, r1);
        check(r0, 8'hc3);
        set_wp(1'b0, 1'b0);
        $display("test protect done");
    endtask

    task automatic t_abort();
        logic [7:0] r0;
        logic [7:0] r1;
        logic       ack;
        write_bytes(3'h1, 8'h20, 1, 8'h77, 8'h00, 1'b0);
        i_tnv_bus_master.start();
        i_tnv_bus_master.send({DEV_TYPE, 3'h1, 1'b0}, ack);
        i_tnv_bus_master.send(8'h20, ack);
        i_tnv_bus_master.wr_bits(8'h00, 4);
        read_bytes(3'h1, 1, r0, r1);
        check(r0, 8'h77);
        i_tnv_bus_master.start();
        i_tnv_bus_master.send({DEV_TYPE, 3'h1, 1'b0}, ack);
        i_tnv_bus_master.send(8'h20, ack);
        i_tnv_bus_master.wr_bits(8'h00, 5);
        i_tnv_bus_master.stop();
        i_tnv_bus_master.idle(2);
        i_tnv_bus_master.start();
        i_tnv_bus_master.send({DEV_TYPE ^ 4'hf, 3'h1, 1'b1}, ack);
        check({7'h00, ack}, 8'h01);
        i_tnv_bus_master.stop();
        read_bytes(3'h1, 1, r0, r1);
        check(r0, 8'h77);
        $display("test abort done");
    endtask

    // --------------------------------------------------------------
    // Main sequence
    // --------------------------------------------------------------
    initial begin
        srst      = 1'b1;
        wp_en     = 1'b0;
        wp_val    = 1'b0;
        bad_count = 0;
        n_checks  = 0;
        fork
            begin
                repeat (5) @(posedge clk);
                #1;
                srst = 1'b0;
            end
            i_tnv_bus_master.idle(24);
        join
        i_tnv_bus_master.idle(4);
        check({7'h00, sda_oe}, 8'h00);
        t_basic();
        t_wrap();
        t_protect();
        t_abort();
        give_verdict();
    end

    // The tests need about 21 us; this cuts a hang short.
    initial begin
        #200000;
        bad_count++;
        give_verdict();
    end
endmodule

`default_nettype wire
